// ==== design/ssp_pkg.sv ====
// Package: register map, field positions, reset values and pin carriers of the serial port
package ssp_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [1:0] ADDR_ENABLE_STATUS = 2'h0;
   localparam logic [1:0] ADDR_FORMAT_FLAGS = 2'h1;
   localparam logic [1:0] ADDR_SHIFT_DATA = 2'h2;
   localparam logic [7:0] RST_ENABLE_STATUS = 8'hE0;
   localparam logic [7:0] RST_FORMAT_FLAGS = 8'h00;
   // port_enable_status fields
   localparam int EN_MODE_LSB = 5;
   localparam int EN_PORT_EN = 1;
   localparam int EN_INCOMPLETE = 0;
   // port_format_flags fields
   localparam int FMT_POLARITY = 5;
   localparam int FMT_EDGE = 4;
   localparam int FMT_MSB_FIRST = 3;
   localparam int FMT_SEL_EN = 2;
   localparam int FMT_WCOL = 1;
   localparam int FMT_DONE = 0;
   // Mode codes
   localparam logic [2:0] MODE_DIV4 = 3'h0;
   localparam logic [2:0] MODE_DIV16 = 3'h1;
   localparam logic [2:0] MODE_DIV64 = 3'h2;
   localparam logic [2:0] MODE_SUB = 3'h3;
   localparam logic [2:0] MODE_TMR = 3'h4;
   localparam logic [2:0] MODE_SLAVE = 3'h5;
   // Bits per byte and half-period counts of the internal divider
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [5:0] HALF_DIV4 = 6'h01;
   localparam logic [5:0] HALF_DIV16 = 6'h07;
   localparam logic [5:0] HALF_DIV64 = 6'h1F;

   typedef struct packed {
      logic sclk;
      logic sdo;
      logic sdo_oe;
      logic sclk_oe;
   } ssp_pins_out_t;
endpackage

// ==== design/ssp_sync.sv ====
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ssp_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// ==== design/ssp_ctrl.sv ====
// Serial peripheral port controller: registers, master clock generator, shifter
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Function
// R1: Port enable bit switches the whole port on or off.
// R2: Disabled port releases all four pins to other functions.
// R3: Slave, select rises mid-byte: set incomplete and complete flags together.
// R4: Software writing incomplete flag never sets complete flag.
// R5: Incomplete flag set by hardware only in slave mode.
// R6: Master clock idles high for polarity 0, low for polarity 1.
// R7: Polarity and edge bits choose the sampling edge.
// R8: Bit order bit picks LSB or MSB first; both ends agree.
// R9: Select enable 0 leaves select unused; 1 makes it active.
// R10: Data write during a byte is dropped and sets write collision flag.
// R11: Every finished byte sets the complete flag until software clears it.
// R12: Master data write starts clocks and full-duplex shifting at once.
// R13: Slave shifts data on clocks from the external master.
// R14: External master asserts select before clocks, data timed to mode.
// R15: Port keeps running while its clock source runs.
// R16: Enabled and idle: input floats, output driven high. Code: a slave releases it when deselected, else drives its data bit.
// R17: Slave never drives the clock pin.
// R18: Received bits collect in a shift buffer, copied when byte completes.
// R19: Bus active with select enable set and select low, then data write.
// R20: Software sequence: mode, format, enable, write, check flags, read, clear.
// R21: Mode field codes 0..4 master with clock source, 5 slave.
// R22: One eight-bit data register carries both sent and received bytes.
// R23: Eight clock edges per byte; count reset on disable or deselect.
module ssp_ctrl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Register port
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Slower clock sources for master modes 3 and 4
   input wire logic sub_tick_i,
   input wire logic tmr_tick_i,
   // Serial pins
   input wire logic sclk_i,
   input wire logic sdi_i,
   input wire logic ssel_n_i,
   output logic sclk_o,
   output logic sclk_oe_o,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic pins_owned_o,
   output logic done_o
);
   // ****************************************
   // Registers and state
   // ****************************************
   logic [2:0] mode_q;
   logic port_en_q, incomplete_q;
   logic polarity_q, edge_q, msb_first_q, sel_en_q, wcol_q, done_q;
   logic [7:0] data_q, shift_q, rx_q;
   logic [2:0] m_smp_q, m_last_q;
   logic [3:0] bit_cnt_q;
   logic [5:0] div_q;
   logic busy_q, phase_q, sclk_q;
   logic [2:0] sync;
   logic sclk_s, sdi_s, ssel_n_s, sclk_prev_q;
   ssp_pkg::ssp_pins_out_t pins_q;

   ssp_sync #(.WIDTH(3)) u_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .async_i({sclk_i, sdi_i, ssel_n_i}),
      .sync_o(sync)
   );
   assign {sclk_s, sdi_s, ssel_n_s} = sync;

   wire is_slave = (mode_q == ssp_pkg::MODE_SLAVE);
   wire is_master = (mode_q <= ssp_pkg::MODE_TMR);
   wire wr_data = wr_i && (addr_i == ssp_pkg::ADDR_SHIFT_DATA);
   wire wr_en = wr_i && (addr_i == ssp_pkg::ADDR_ENABLE_STATUS); // R20
   wire wr_fmt = wr_i && (addr_i == ssp_pkg::ADDR_FORMAT_FLAGS);
   // Select counts only when its function is enabled
   wire selected = !sel_en_q || !ssel_n_s; // R9
   // Sampling edge: rising when polarity equals edge bit
   wire sample_rising = (polarity_q == edge_q); // R7

   // ****************************************
   // Master clock divider
   // ****************************************
   logic [5:0] half;
   always_comb begin
      unique case (mode_q)
         ssp_pkg::MODE_DIV4: half = ssp_pkg::HALF_DIV4;
         ssp_pkg::MODE_DIV16: half = ssp_pkg::HALF_DIV16;
         default: half = ssp_pkg::HALF_DIV64;
      endcase
   end
   logic tick;
   always_comb begin
      unique case (mode_q)
         ssp_pkg::MODE_SUB: tick = sub_tick_i; // R15
         ssp_pkg::MODE_TMR: tick = tmr_tick_i;
         default: tick = (div_q == half);
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (srst_i || !busy_q || tick) begin
         div_q <= 6'h00;
      end else begin
         div_q <= div_q + 6'h01;
      end
   end

   // ****************************************
   // Shift events
   // ****************************************
   logic slave_sample, slave_shift, m_sample, m_shift;
   wire sclk_rise = sclk_s && !sclk_prev_q;
   wire sclk_fall = !sclk_s && sclk_prev_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end
   always_comb begin
      slave_sample = is_slave && selected && port_en_q &&
                     (sample_rising ? sclk_rise : sclk_fall); // R13
      slave_shift = is_slave && selected && port_en_q &&
                    (sample_rising ? sclk_fall : sclk_rise);
      m_sample = is_master && busy_q && tick && !phase_q;
      m_shift = is_master && busy_q && tick && phase_q;
   end
   wire do_sample = m_sample || slave_sample;
   wire do_shift = m_shift || slave_shift;
   wire last_bit = (bit_cnt_q == ssp_pkg::BITS_PER_BYTE - 4'h1);
   wire byte_done = do_sample && last_bit; // R23
   // Master receive lags its own clock pin by the pin register and the input
   // synchroniser, so the capture runs three cycles behind the sampling tick
   always_ff @(posedge clk_i) begin
      if (srst_i || !port_en_q || !is_master) begin
         m_smp_q <= 3'h0;
         m_last_q <= 3'h0;
      end else begin
         m_smp_q <= {m_smp_q[1:0], m_sample};
         m_last_q <= {m_last_q[1:0], m_sample && last_bit};
      end
   end
   wire rx_take = slave_sample || m_smp_q[2];
   wire done_take = (slave_sample && last_bit) || m_last_q[2]; // R11 R18
   // A byte counts as moving until its last received bit has landed
   wire in_flight = busy_q || (bit_cnt_q != 4'h0) || (m_last_q != 3'h0);
   wire slave_sel = is_slave && selected;
   // Select raised by master while a byte is partly shifted
   wire aborted = is_slave && port_en_q && sel_en_q && ssel_n_s &&
                  (bit_cnt_q != 4'h0); // R3 R5
   wire wr_collide = wr_data && in_flight; // R10

   // ****************************************
   // Bit counter and busy
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i || !port_en_q || (is_slave && sel_en_q && ssel_n_s)) begin
         bit_cnt_q <= 4'h0; // R23
      end else if (byte_done) begin
         bit_cnt_q <= 4'h0;
      end else if (do_sample) begin
         bit_cnt_q <= bit_cnt_q + 4'h1; // R23
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i || !port_en_q || !is_master) begin
         busy_q <= 1'b0;
         phase_q <= 1'b0;
      end else if (wr_data && !in_flight && selected) begin
         busy_q <= 1'b1; // R12 R19
         phase_q <= !edge_q;
      end else if (tick && busy_q) begin
         phase_q <= !phase_q;
         // Last sample ends the byte; the clock then returns to its idle level
         if (byte_done) begin
            busy_q <= 1'b0;
         end
      end
   end
   // Master clock level toggles on each tick; idle level set by polarity
   always_ff @(posedge clk_i) begin
      if (srst_i || !busy_q) begin
         sclk_q <= !polarity_q; // R6
      end else if (tick) begin
         sclk_q <= !sclk_q;
      end
   end

   // ****************************************
   // Data register and shift buffer
   // ****************************************
   // Outgoing bit is taken from the front of the shift buffer
   wire out_bit = msb_first_q ? shift_q[7] : shift_q[0]; // R8
   logic sdo_bit_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         shift_q <= 8'h00;
         sdo_bit_q <= 1'b1;
      end else if (wr_data && !in_flight) begin
         shift_q <= wdata_i; // R22
         sdo_bit_q <= msb_first_q ? wdata_i[7] : wdata_i[0];
      end else if (do_sample) begin
         shift_q <= msb_first_q ? {shift_q[6:0], 1'b0} : {1'b0, shift_q[7:1]}; // R8 R13
      end else if (do_shift) begin
         sdo_bit_q <= out_bit;
      end
   end
   wire [7:0] rx_next = msb_first_q ? {rx_q[6:0], sdi_s} : {sdi_s, rx_q[7:1]};
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rx_q <= 8'h00;
      end else if (rx_take) begin
         rx_q <= rx_next; // R8 R13 R18
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         data_q <= 8'h00;
      end else if (done_take) begin
         data_q <= rx_next; // R18
      end else if (wr_data && !in_flight) begin
         data_q <= wdata_i; // R22
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mode_q <= ssp_pkg::RST_ENABLE_STATUS[7:5];
         port_en_q <= 1'b0;
      end else if (wr_en) begin
         mode_q <= wdata_i[7:5]; // R21
         port_en_q <= wdata_i[ssp_pkg::EN_PORT_EN]; // R1
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         incomplete_q <= 1'b0;
      end else if (aborted) begin
         incomplete_q <= 1'b1; // R3
      end else if (wr_en) begin
         incomplete_q <= wdata_i[ssp_pkg::EN_INCOMPLETE]; // R4
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         {polarity_q, edge_q, msb_first_q, sel_en_q} <= ssp_pkg::RST_FORMAT_FLAGS[5:2];
      end else if (wr_fmt) begin
         {polarity_q, edge_q, msb_first_q, sel_en_q} <= wdata_i[5:2];
      end
   end
   // Set wins over a clear that arrives in the same cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wcol_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         if (wr_collide) begin
            wcol_q <= 1'b1; // R10
         end else if (wr_fmt) begin
            wcol_q <= wdata_i[ssp_pkg::FMT_WCOL];
         end
         if (done_take || aborted) begin
            done_q <= 1'b1; // R11 R3
         end else if (wr_fmt) begin
            done_q <= wdata_i[ssp_pkg::FMT_DONE];
         end
      end
   end

   // ****************************************
   // Read port and pins
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            ssp_pkg::ADDR_ENABLE_STATUS:
               rdata_o <= {mode_q, 3'h0, port_en_q, incomplete_q};
            ssp_pkg::ADDR_FORMAT_FLAGS:
               rdata_o <= {2'h0, polarity_q, edge_q, msb_first_q, sel_en_q, wcol_q, done_q};
            ssp_pkg::ADDR_SHIFT_DATA: rdata_o <= data_q;
            default: rdata_o <= 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pins_q <= '0;
         pins_owned_o <= 1'b0;
      end else begin
         pins_owned_o <= port_en_q; // R2
         pins_q.sclk <= sclk_q;
         pins_q.sclk_oe <= port_en_q && is_master; // R6 R17
         // Output idles high when no byte is moving and the port is not a selected slave
         pins_q.sdo <= (in_flight || slave_sel) ? sdo_bit_q : 1'b1; // R16
         pins_q.sdo_oe <= port_en_q && (is_master || selected); // R16 R2
      end
   end
   assign sclk_o = pins_q.sclk;
   assign sclk_oe_o = pins_q.sclk_oe;
   assign sdo_o = pins_q.sdo;
   assign sdo_oe_o = pins_q.sdo_oe;
   assign done_o = done_q;

   // ****************************************
   // Checks
   // ****************************************
   property p_collision;
      @(posedge clk_i) disable iff (srst_i)
      wr_collide && !done_take |=> wcol_q && $stable(data_q);
   endproperty
   a_collision: assert property (p_collision) else $error("collision not flagged"); // R10
   property p_done_sticky;
      @(posedge clk_i) disable iff (srst_i)
      done_q && !wr_fmt |=> done_q;
   endproperty
   a_done_sticky: assert property (p_done_sticky) else $error("done flag lost"); // R11
   property p_abort;
      @(posedge clk_i) disable iff (srst_i)
      aborted |=> incomplete_q && done_q;
   endproperty
   a_abort: assert property (p_abort) else $error("abort flags missing"); // R3
   property p_no_sw_done;
      @(posedge clk_i) disable iff (srst_i)
      wr_en && !aborted && !done_take && !done_q && !wr_fmt |=> !done_q;
   endproperty
   a_no_sw_done: assert property (p_no_sw_done) else $error("done set by sw"); // R4
   property p_master_inc;
      @(posedge clk_i) disable iff (srst_i)
      !is_slave && !wr_en && !incomplete_q |=> !incomplete_q;
   endproperty
   a_master_inc: assert property (p_master_inc) else $error("incomplete in master"); // R5
   property p_idle_clk;
      @(posedge clk_i) disable iff (srst_i)
      !busy_q ##1 (!busy_q && $stable(polarity_q)) |-> sclk_q == !polarity_q;
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("idle clock level"); // R6
   property p_slave_clk;
      @(posedge clk_i) disable iff (srst_i)
      is_slave ##1 is_slave |-> !sclk_oe_o;
   endproperty
   a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock"); // R17
   property p_start;
      @(posedge clk_i) disable iff (srst_i)
      wr_data && !in_flight && selected && port_en_q && is_master |=> busy_q;
   endproperty
   a_start: assert property (p_start) else $error("master did not start"); // R12
   property p_count;
      @(posedge clk_i) disable iff (srst_i)
      bit_cnt_q <= ssp_pkg::BITS_PER_BYTE - 4'h1;
   endproperty
   a_count: assert property (p_count) else $error("bit count overflow"); // R23
   c_master_byte: cover property (@(posedge clk_i) disable iff (srst_i) m_sample && last_bit);
   c_slave_byte: cover property (@(posedge clk_i) disable iff (srst_i) slave_sample && last_bit);
   c_abort: cover property (@(posedge clk_i) disable iff (srst_i) aborted);
   c_collide: cover property (@(posedge clk_i) disable iff (srst_i) wr_collide);
endmodule

// ==== verif/ssp_peer.sv ====
// Far-side serial device model: shifts one byte out and one in per select
`timescale 1ns/1ps
module ssp_peer (
   // Link
   input wire logic sclk_i,
   input wire logic ssel_n_i,
   input wire logic sdo_i,
   output logic sdi_o,
   // Format {polarity, edge, msb first} and data
   input wire logic [2:0] fmt_i,
   input wire logic [7:0] tx_i,
   output logic [7:0] rx_o
);
   logic [3:0] cnt_q;
   function automatic logic pick(input logic [3:0] k);
      pick = fmt_i[0] ? tx_i[7-k] : tx_i[k];
   endfunction
   initial begin
      sdi_o = 1'b0;
      rx_o = 8'h00;
      cnt_q = 4'h0;
   end
   always @(negedge ssel_n_i) begin
      cnt_q = 4'h0;
      sdi_o = pick(4'h0);
   end
   // Released line shows the inverse of its last bit, never a stale copy
   always @(posedge ssel_n_i) sdi_o = ~sdi_o;
   always @(sclk_i) begin
      if (!ssel_n_i && cnt_q < 4'h8) begin
         if (sclk_i == (fmt_i[2] == fmt_i[1])) begin
            rx_o = fmt_i[0] ? {rx_o[6:0], sdo_i} : {sdo_i, rx_o[7:1]};
            cnt_q = cnt_q + 4'h1;
         end else begin
            // Launch edge only: a real slave holds data through the sample edge
            sdi_o = pick(cnt_q);
         end
      end
   end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the serial port controller
`timescale 1ns/1ps
module testbench;
   // ****************************************
   // Signals
   // ****************************************
   logic clk_i, srst_i, wr_i, rd_i, sub_tick_i, tmr_tick_i, m_sclk, m_sdi, ssel_n, slv;
   logic sclk_o, sclk_oe_o, sdo_o, sdo_oe_o, pins_owned_o, done_o, p_sdi;
   logic [1:0] addr_i, tc;
   logic [2:0] fmt;
   logic [7:0] wdata_i, rdata_o, rx, ptx, d, e;
   int mismatches, n_checks, seed, m, k;
   wire sclk_w;
   wire sdi_w;
   assign sclk_w = sclk_oe_o ? sclk_o : m_sclk;
   assign sdi_w = slv ? m_sdi : p_sdi;

   ssp_ctrl i_ssp_ctrl (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sub_tick_i(sub_tick_i),
      .tmr_tick_i(tmr_tick_i), .sclk_i(sclk_w), .sdi_i(sdi_w), .ssel_n_i(ssel_n),
      .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
      .pins_owned_o(pins_owned_o), .done_o(done_o));
   ssp_peer i_ssp_peer (.sclk_i(sclk_w), .ssel_n_i(ssel_n), .sdo_i(sdo_o), .sdi_o(p_sdi),
      .fmt_i(fmt), .tx_i(ptx), .rx_o(rx));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // Clock sources for the two slow master modes
   always @(posedge clk_i) begin
      tc <= tc + 2'h1;
      sub_tick_i <= (tc == 2'h3);
      tmr_tick_i <= (tc == 2'h1);
   end
   // ****************************************
   // Tasks
   // ****************************************
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, v);
   endtask
   task wait_done;
      for (k = 0; k < 3000 && done_o !== 1'b1; k++) @(posedge clk_i);
      #1 chk(done_o, 8'h01);
   endtask
   // External master; its clock edges come 7 ns after a rising edge of clk_i
   task shift_in(input logic [7:0] v, input int n);
      @(posedge clk_i);
      #7 ssel_n = 1'b0;
      #400;
      for (k = 0; k < n; k++) begin
         // Data moves on the launch edge, which comes first when the edge bit is 0
         if (fmt[1]) m_sdi = fmt[0] ? v[7-k] : v[k];
         #200 m_sclk = ~m_sclk;
         if (!fmt[1]) m_sdi = fmt[0] ? v[7-k] : v[k];
         #200 m_sclk = ~m_sclk;
      end
      #400 ssel_n = 1'b1;
      m_sdi = ~m_sdi;
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #500000;
      mismatches++;
      wrap_up;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 32'h8bd8;
      mismatches = 0;
      n_checks = 0;
      {srst_i, wr_i, rd_i, addr_i, wdata_i, tc, sub_tick_i, tmr_tick_i} = 17'h10000;
      {m_sclk, m_sdi, ssel_n, slv, fmt, ptx} = 15'h1000;
      repeat (3) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(2'h0, 8'hE0);
      rd(2'h1, 8'h00);
      rd(2'h3, 8'h00);
      chk(pins_owned_o, 8'h00);
      for (m = 0; m < 5; m++) begin
         fmt = $random(seed);
         d = $random(seed);
         ptx = $random(seed);
         m_sclk = ~fmt[2];
         wr(2'h1, {2'h0, fmt, 3'h4});
         wr(2'h0, {m[2:0], 5'h02});
         repeat (4) @(posedge clk_i);
         chk({sclk_oe_o, sclk_o, sdo_oe_o, sdo_o, pins_owned_o}, {4'h1, ~fmt[2], 3'h7});
         @(posedge clk_i);
         ssel_n <= 1'b0;
         // Select needs the two synchroniser stages before the data write
         repeat (2) @(posedge clk_i);
         wr(2'h2, d);
         wr(2'h2, ~d);
         wait_done;
         @(posedge clk_i);
         ssel_n <= 1'b1;
         chk(rx, d);
         rd(2'h2, ptx);
         rd(2'h1, {2'h0, fmt, 3'h7});
         rd(2'h0, {m[2:0], 5'h02});
         wr(2'h1, {2'h0, fmt, 3'h4});
         rd(2'h1, {2'h0, fmt, 3'h4});
      end
      wr(2'h0, 8'h83);
      repeat (4) @(posedge clk_i);
      chk(done_o, 8'h00);
      rd(2'h0, 8'h83);
      slv = 1'b1;
      fmt = $random(seed);
      m_sclk = ~fmt[2];
      wr(2'h0, 8'hA2);
      wr(2'h1, {2'h0, fmt, 3'h4});
      repeat (4) @(posedge clk_i);
      chk(sclk_oe_o, 8'h00);
      e = $random(seed);
      shift_in(e, 3);
      repeat (10) @(posedge clk_i);
      rd(2'h0, 8'hA3);
      rd(2'h1, {2'h0, fmt, 3'h5});
      wr(2'h0, 8'hA2);
      for (m = 0; m < 4; m++) begin
         d = $random(seed);
         fmt = {m[1:0], d[0]};
         m_sclk = ~fmt[2];
         wr(2'h1, {2'h0, fmt, 3'h4});
         d = $random(seed);
         e = $random(seed);
         wr(2'h2, d);
         shift_in(e, 8);
         repeat (10) @(posedge clk_i);
         chk(rx, d);
         rd(2'h2, e);
         rd(2'h1, {2'h0, fmt, 3'h5});
         rd(2'h0, 8'hA2);
         wr(2'h1, {2'h0, fmt, 3'h4});
      end
      wr(2'h0, 8'hA0);
      repeat (4) @(posedge clk_i);
      chk({pins_owned_o, sclk_oe_o, sdo_oe_o}, 8'h00);
      wrap_up;
   end
endmodule
